// file: bench/cpu_byte_master.sv
/*
 * CPU-side model of the timer byte bus: byte and wide accesses.
 * Assumes its tasks are called one at a time from one process.
 */
`timescale 1ns/10ps
module cpu_byte_master
    import timer16_pkg::*;
(
    // Clock
    input wire logic sys_clk_i,
    // Byte bus
    output timer16_pkg::byte_addr_t bus_addr_o,
    output logic bus_wr_o,
    output logic bus_rd_o,
    output logic [7:0] bus_wdata_o,
    input wire logic [7:0] bus_rdata_i
);
    import timer16_pkg::*;

    initial
    begin
        bus_addr_o = ADDR_CNT_L;
        bus_wr_o = 1'b0;
        bus_rd_o = 1'b0;
        bus_wdata_o = 8'hA5;
    end

    // One byte per strobe, wide values never go out in one transfer
    task automatic wr_byte(input byte_addr_t a, input logic [7:0] d);
        @(negedge sys_clk_i);
        bus_addr_o = a;
        bus_wdata_o = d;
        bus_wr_o = 1'b1;
        @(negedge sys_clk_i);
        bus_wr_o = 1'b0;
        // Stale data must not look valid after the strobe
        bus_wdata_o = ~d;
    endtask

    task automatic rd_byte(input byte_addr_t a, output logic [7:0] d);
        @(negedge sys_clk_i);
        bus_addr_o = a;
        bus_rd_o = 1'b1;
        @(negedge sys_clk_i);
        bus_rd_o = 1'b0;
        d = bus_rdata_i;
    endtask

    // Whole wide access from one caller, nothing interleaved
    task automatic wr_wide(input byte_addr_t a, input logic [15:0] v);
        wr_byte(a | 3'h1, v[15:8]);
        wr_byte(a, v[7:0]);
    endtask

    task automatic rd_wide(input byte_addr_t a, output logic [15:0] v);
        rd_byte(a, v[7:0]);
        rd_byte(a | 3'h1, v[15:8]);
    endtask
endmodule

// file: bench/tb_timer16_byte_access_capture.sv
/*
 * Self-checking bench of the timer byte access path and capture unit.
 * Assumes the CPU model drives the byte bus at falling edges.
 */
`timescale 1ns/10ps
module tb_timer16_byte_access_capture;
    import timer16_pkg::*;

    typedef struct {byte_addr_t a; logic [3:0] m; logic [15:0] v;} row_t;

    logic sys_clk_i, arst_n_i, bus_wr_i, bus_rd_i, count_en_i;
    byte_addr_t bus_addr_i;
    logic [7:0] bus_wdata_i, bus_rdata_o, b;
    logic [3:0] waveform_mode_select_i;
    logic capture_source_i, capture_edge_i, capture_irq_enable_i;
    logic overflow_irq_enable_i, capture_pin_i, comparator_output_i;
    logic capture_flag_write_i, capture_flag_wdata_i;
    logic capture_vector_ack_i, overflow_flag_write_i;
    logic overflow_flag_wdata_i, overflow_vector_ack_i;
    logic capture_flag_o, overflow_flag_o, capture_irq_o, overflow_irq_o;
    logic [15:0] counter_value_o, compare_a_value_o, v;
    logic [15:0] compare_b_value_o, capture_value_o;
    int err_total = 0;
    int checks_done = 0;
    row_t rows[7] = '{'{ADDR_CNT_L, 4'h0, 16'h01FF},
        '{ADDR_CMPA_L, 4'h0, 16'h1234}, '{ADDR_CMPB_L, 4'h0, 16'hBEEF},
        '{ADDR_CAP_L, 4'h8, 16'hC0DE}, '{ADDR_CAP_L, 4'hA, 16'h3C5A},
        '{ADDR_CAP_L, 4'hC, 16'hA55A}, '{ADDR_CAP_L, 4'hE, 16'h7E81}};

    timer16_byte_access_capture timer16_byte_access_capture_i (
        .sys_clk_i, .arst_n_i, .bus_addr_i, .bus_wr_i, .bus_rd_i,
        .bus_wdata_i, .bus_rdata_o, .waveform_mode_select_i, .count_en_i,
        .capture_source_i, .capture_edge_i, .capture_irq_enable_i,
        .overflow_irq_enable_i, .capture_pin_i, .comparator_output_i,
        .capture_flag_write_i, .capture_flag_wdata_i, .capture_vector_ack_i,
        .overflow_flag_write_i, .overflow_flag_wdata_i,
        .overflow_vector_ack_i, .capture_flag_o, .overflow_flag_o,
        .capture_irq_o, .overflow_irq_o, .counter_value_o,
        .compare_a_value_o, .compare_b_value_o, .capture_value_o);

    cpu_byte_master cpu_byte_master_i (.sys_clk_i(sys_clk_i),
        .bus_addr_o(bus_addr_i), .bus_wr_o(bus_wr_i), .bus_rd_o(bus_rd_i),
        .bus_wdata_o(bus_wdata_i), .bus_rdata_i(bus_rdata_o));

    initial
    begin
        sys_clk_i = 1'b0;
        forever #2.5 sys_clk_i = ~sys_clk_i;
    end

    task automatic check(input string n, input logic [15:0] s,
                         input logic [15:0] e);
        checks_done++;
        if (s !== e)
        begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask

    task automatic results();
        $display("checks %0d errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    function automatic logic [15:0] port_of(input byte_addr_t a);
        case (a)
            ADDR_CNT_L: return counter_value_o;
            ADDR_CMPA_L: return compare_a_value_o;
            ADDR_CMPB_L: return compare_b_value_o;
            default: return capture_value_o;
        endcase
    endfunction

    task automatic ticks(input int n);
        repeat (n) @(negedge sys_clk_i);
    endtask

    initial
    begin
        #100000;
        err_total++;
        results();
    end

    initial
    begin
        {arst_n_i, count_en_i, waveform_mode_select_i} = '0;
        {capture_source_i, capture_edge_i, capture_irq_enable_i} = '0;
        {overflow_irq_enable_i, capture_pin_i, comparator_output_i} = '0;
        {capture_flag_write_i, capture_flag_wdata_i} = '0;
        {capture_vector_ack_i, overflow_flag_write_i} = '0;
        {overflow_flag_wdata_i, overflow_vector_ack_i} = '0;
        ticks(10);
        arst_n_i = 1'b1;
        check("cap flag", capture_flag_o, 16'h0);
        check("ovf flag", overflow_flag_o, 16'h0);
        check("cap irq", capture_irq_o, 16'h0);
        foreach (rows[i])
        begin
            waveform_mode_select_i = rows[i].m;
            cpu_byte_master_i.wr_wide(rows[i].a, rows[i].v);
            check("port", port_of(rows[i].a), rows[i].v);
            cpu_byte_master_i.rd_wide(rows[i].a, v);
            check("wide read", v, rows[i].v);
        end
        // Capture write outside capture-top modes is dropped
        waveform_mode_select_i = 4'h0;
        cpu_byte_master_i.wr_wide(ADDR_CAP_L, 16'h5555);
        check("cap locked", capture_value_o, 16'h7E81);
        cpu_byte_master_i.rd_byte(ADDR_CNT_L, b);
        cpu_byte_master_i.rd_byte(ADDR_CMPA_H, b);
        check("cmp direct", b, 16'h12);
        cpu_byte_master_i.rd_byte(ADDR_CNT_H, b);
        check("latch kept", b, 16'h01);
        // Capture lands between low and high read: high comes from latch
        cpu_byte_master_i.rd_byte(ADDR_CAP_L, b);
        capture_edge_i = EDGE_RISING;
        capture_irq_enable_i = 1'b1;
        comparator_output_i = 1'b1;
        ticks(1);
        capture_pin_i = 1'b1;
        ticks(2);
        check("cap value", capture_value_o, 16'h01FF);
        check("cap flag", capture_flag_o, 16'h1);
        check("cap irq", capture_irq_o, 16'h1);
        cpu_byte_master_i.rd_byte(ADDR_CAP_H, b);
        check("cap high", b, 16'h7E);
        capture_flag_write_i = 1'b1;
        ticks(1);
        capture_flag_write_i = 1'b0;
        ticks(1);
        check("write zero", capture_flag_o, 16'h1);
        {capture_flag_write_i, capture_flag_wdata_i} = 2'b11;
        ticks(1);
        {capture_flag_write_i, capture_flag_wdata_i} = 2'b00;
        ticks(1);
        check("write one", capture_flag_o, 16'h0);
        // Falling edge of comparator, interrupt disabled
        cpu_byte_master_i.wr_wide(ADDR_CNT_L, 16'h2A3C);
        capture_irq_enable_i = 1'b0;
        capture_source_i = SRC_COMPARATOR;
        capture_edge_i = EDGE_FALLING;
        ticks(1);
        comparator_output_i = 1'b0;
        ticks(2);
        check("cmp capture", capture_value_o, 16'h2A3C);
        check("masked irq", capture_irq_o, 16'h0);
        capture_vector_ack_i = 1'b1;
        ticks(1);
        capture_vector_ack_i = 1'b0;
        ticks(1);
        check("vector ack", capture_flag_o, 16'h0);
        // Wrap at the top of the fixed-top mode
        cpu_byte_master_i.wr_wide(ADDR_CNT_L, 16'hFFFF);
        overflow_irq_enable_i = 1'b1;
        count_en_i = 1'b1;
        ticks(1);
        count_en_i = 1'b0;
        ticks(1);
        check("wrap", counter_value_o, 16'h0000);
        check("ovf flag", overflow_flag_o, 16'h1);
        check("ovf irq", overflow_irq_o, 16'h1);
        {overflow_flag_write_i, overflow_flag_wdata_i} = 2'b11;
        ticks(1);
        {overflow_flag_write_i, overflow_flag_wdata_i} = 2'b00;
        ticks(1);
        check("ovf clear", overflow_flag_o, 16'h0);
        // Capture-top mode: the counter wraps at the capture value
        waveform_mode_select_i = 4'h8;
        cpu_byte_master_i.wr_wide(ADDR_CNT_L, 16'h2A3C);
        count_en_i = 1'b1;
        ticks(1);
        count_en_i = 1'b0;
        ticks(1);
        check("top wrap", counter_value_o, 16'h0000);
        check("top ovf", overflow_flag_o, 16'h1);
        overflow_vector_ack_i = 1'b1;
        ticks(1);
        overflow_vector_ack_i = 1'b0;
        ticks(1);
        check("ovf vector", overflow_flag_o, 16'h0);
        // Reset in mid-run; a pin already high must not count as an edge
        arst_n_i = 1'b0;
        capture_source_i = SRC_PIN;
        capture_edge_i = EDGE_RISING;
        ticks(2);
        arst_n_i = 1'b1;
        ticks(2);
        check("rst cap", capture_value_o, 16'h0000);
        check("rst flag", capture_flag_o, 16'h0);
        check("rst cnt", counter_value_o, 16'h0000);
        cpu_byte_master_i.rd_byte(ADDR_CNT_H, b);
        check("rst latch", b, 16'h00);
        results();
    end
endmodule

// file: design/capture_edge_detect.sv
/*
 * Edge detector of the capture unit: picks the trigger source and
 * emits a one-cycle trigger on the selected edge.
 * Assumes both sources are already synchronous to sys_clk_i.
 */
`timescale 1ns/10ps
module capture_edge_detect
    import timer16_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic arst_n_i,
    // Sources and settings
    input wire logic capture_pin_i,
    input wire logic comparator_output_i,
    input wire logic source_sel_i,
    input wire logic edge_sel_i,
    // Trigger
    output logic trigger_o
);
    logic level;
    logic prev_q;
    logic prev_d;
    logic valid_q;
    logic valid_d;

    always_comb
    begin
        level = (source_sel_i == SRC_COMPARATOR) ? comparator_output_i
                                                 : capture_pin_i;
        prev_d = level;
        valid_d = 1'b1;
    end

    always_ff @(posedge sys_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            prev_q <= 1'b0;
            valid_q <= 1'b0;
        end
        else
        begin
            prev_q <= prev_d;
            valid_q <= valid_d;
        end
    end

    // First cycle after reset has no history, so no false edge
    // Switching the source may show as an edge; software should expect it
    always_comb
    begin
        if (!valid_q)
            trigger_o = 1'b0;
        else if (edge_sel_i == EDGE_RISING)
            trigger_o = level && !prev_q;
        else
            trigger_o = !level && prev_q;
    end

endmodule

// file: design/timer16_byte_access_capture.sv
/*
 * Byte-wide access path of a 16-bit timer (counter, two compare and
 * one capture register behind one shared high-byte latch) with the
 * input capture unit and a simple up counter with overflow flag.
 * Assumes a CPU that issues at most one byte access per cycle and
 * keeps wide accesses in order and uninterrupted.
 */
// Function
// - Wide registers reached as two byte accesses
// - One shared high-byte latch for all registers
// - Low write loads latch and byte together
// - Low read copies upper byte into latch
// - Compare reads bypass and keep the latch
// - Overflow flag set per mode, may interrupt
// - Capture on selected edge of chosen source
// - Trigger copies counter into capture register
// - Capture flag set in copy cycle
// - Enabled flag raises capture interrupt request
// - Flag clears when vector is executed
// - Writing one clears flag, zero keeps
// - Capture high read returns the latch
// - Capture writable only in capture-top modes
`timescale 1ns/10ps
module timer16_byte_access_capture
    import timer16_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic arst_n_i,
    // CPU byte bus
    input wire timer16_pkg::byte_addr_t bus_addr_i,
    input wire logic bus_wr_i,
    input wire logic bus_rd_i,
    input wire logic [7:0] bus_wdata_i,
    output logic [7:0] bus_rdata_o,
    // Configuration
    input wire logic [3:0] waveform_mode_select_i,
    input wire logic count_en_i,
    input wire logic capture_source_i,
    input wire logic capture_edge_i,
    input wire logic capture_irq_enable_i,
    input wire logic overflow_irq_enable_i,
    // Event sources
    input wire logic capture_pin_i,
    input wire logic comparator_output_i,
    // Flag control
    input wire logic capture_flag_write_i,
    input wire logic capture_flag_wdata_i,
    input wire logic capture_vector_ack_i,
    input wire logic overflow_flag_write_i,
    input wire logic overflow_flag_wdata_i,
    input wire logic overflow_vector_ack_i,
    // Status and requests
    output logic capture_flag_o,
    output logic overflow_flag_o,
    output logic capture_irq_o,
    output logic overflow_irq_o,
    output logic [15:0] counter_value_o,
    output logic [15:0] compare_a_value_o,
    output logic [15:0] compare_b_value_o,
    output logic [15:0] capture_value_o
);
    import timer16_pkg::*;

    logic [15:0] counter_value_q, counter_value_d;
    logic [15:0] compare_a_q, compare_a_d;
    logic [15:0] compare_b_q, compare_b_d;
    logic [15:0] capture_value_q, capture_value_d;
    logic [7:0] high_latch_q, high_latch_d;
    logic [7:0] rdata_q, rdata_d;
    logic capture_flag_q, capture_flag_d;
    logic overflow_flag_q, overflow_flag_d;

    logic cap_trigger;
    logic cap_is_top;
    logic [15:0] top_value;
    logic wrap;
    logic wr_low;
    logic wr_high;
    logic rd_low;
    logic [15:0] low_target;

    capture_edge_detect u_edge
    (
        .sys_clk_i(sys_clk_i),
        .arst_n_i(arst_n_i),
        .capture_pin_i(capture_pin_i),
        .comparator_output_i(comparator_output_i),
        .source_sel_i(capture_source_i),
        .edge_sel_i(capture_edge_i),
        .trigger_o(cap_trigger)
    );

    // Decoding: even address is the low byte, odd the high byte
    always_comb
    begin
        wr_low = bus_wr_i && !bus_addr_i[0];
        wr_high = bus_wr_i && bus_addr_i[0];
        rd_low = bus_rd_i && !bus_wr_i && !bus_addr_i[0];
        cap_is_top = CAP_TOP_MODES[waveform_mode_select_i];
        top_value = cap_is_top ? capture_value_q : COUNT_MAX;
        wrap = count_en_i && (counter_value_q == top_value);
        case (bus_addr_i)
            ADDR_CNT_L: low_target = counter_value_q;
            ADDR_CMPA_L: low_target = compare_a_q;
            ADDR_CMPB_L: low_target = compare_b_q;
            ADDR_CAP_L: low_target = capture_value_q;
            default: low_target = WIDE_RESET;
        endcase
    end

    // Shared high-byte latch
    always_comb
    begin
        high_latch_d = high_latch_q;
        if (wr_high)
            high_latch_d = bus_wdata_i;
        else if (rd_low && bus_addr_i != ADDR_CMPA_L
                 && bus_addr_i != ADDR_CMPB_L)
            high_latch_d = low_target[HIGH_LSB +: 8];
    end

    // Wide registers; a CPU counter write overrides counting
    always_comb
    begin
        counter_value_d = counter_value_q;
        compare_a_d = compare_a_q;
        compare_b_d = compare_b_q;
        capture_value_d = capture_value_q;
        if (wr_low && bus_addr_i == ADDR_CNT_L)
            counter_value_d = {high_latch_q, bus_wdata_i};
        else if (wrap)
            counter_value_d = WIDE_RESET;
        else if (count_en_i)
            counter_value_d = counter_value_q + 16'h0001;
        if (wr_low && bus_addr_i == ADDR_CMPA_L)
            compare_a_d = {high_latch_q, bus_wdata_i};
        if (wr_low && bus_addr_i == ADDR_CMPB_L)
            compare_b_d = {high_latch_q, bus_wdata_i};
        // The hardware stamp wins over a CPU write in the same cycle
        if (cap_trigger)
            capture_value_d = counter_value_q;
        else if (wr_low && bus_addr_i == ADDR_CAP_L && cap_is_top)
            capture_value_d = {high_latch_q, bus_wdata_i};
    end

    // Read data, registered
    always_comb
    begin
        rdata_d = rdata_q;
        if (bus_rd_i && !bus_wr_i)
        begin
            case (bus_addr_i)
                ADDR_CMPA_H: rdata_d = compare_a_q[HIGH_LSB +: 8];
                ADDR_CMPB_H: rdata_d = compare_b_q[HIGH_LSB +: 8];
                ADDR_CNT_H: rdata_d = high_latch_q;
                ADDR_CAP_H: rdata_d = high_latch_q;
                default: rdata_d = low_target[LOW_LSB +: 8];
            endcase
        end
    end

    // Flags: a new event wins over any clear in the same cycle
    always_comb
    begin
        capture_flag_d = capture_flag_q;
        if (cap_trigger)
            capture_flag_d = 1'b1;
        else if (capture_vector_ack_i)
            capture_flag_d = 1'b0;
        else if (capture_flag_write_i && capture_flag_wdata_i)
            capture_flag_d = 1'b0;
        overflow_flag_d = overflow_flag_q;
        if (wrap)
            overflow_flag_d = 1'b1;
        else if (overflow_vector_ack_i)
            overflow_flag_d = 1'b0;
        else if (overflow_flag_write_i && overflow_flag_wdata_i)
            overflow_flag_d = 1'b0;
    end

    always_ff @(posedge sys_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            counter_value_q <= WIDE_RESET;
            compare_a_q <= WIDE_RESET;
            compare_b_q <= WIDE_RESET;
            capture_value_q <= WIDE_RESET;
            high_latch_q <= LATCH_RESET;
            rdata_q <= LATCH_RESET;
            capture_flag_q <= 1'b0;
            overflow_flag_q <= 1'b0;
        end
        else
        begin
            counter_value_q <= counter_value_d;
            compare_a_q <= compare_a_d;
            compare_b_q <= compare_b_d;
            capture_value_q <= capture_value_d;
            high_latch_q <= high_latch_d;
            rdata_q <= rdata_d;
            capture_flag_q <= capture_flag_d;
            overflow_flag_q <= overflow_flag_d;
        end
    end

    always_comb
    begin
        bus_rdata_o = rdata_q;
        capture_flag_o = capture_flag_q;
        overflow_flag_o = overflow_flag_q;
        capture_irq_o = capture_flag_q && capture_irq_enable_i;
        overflow_irq_o = overflow_flag_q && overflow_irq_enable_i;
        counter_value_o = counter_value_q;
        compare_a_value_o = compare_a_q;
        compare_b_value_o = compare_b_q;
        capture_value_o = capture_value_q;
    end

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!arst_n_i);

    chk_latch_high_write: assert property (
        wr_high |=> high_latch_q == $past(bus_wdata_i))
        else $error("high byte write not staged in latch");

    chk_low_write_pair: assert property (
        wr_low && bus_addr_i == ADDR_CMPA_L
        |=> compare_a_q == {$past(high_latch_q), $past(bus_wdata_i)})
        else $error("low write did not load both bytes");

    chk_low_read_latch: assert property (
        rd_low && bus_addr_i == ADDR_CNT_L
        |=> high_latch_q == $past(counter_value_q[15:8])
            ##1 1'b1)
        else $error("low read did not load latch");

    chk_cmp_read_keep: assert property (
        bus_rd_i && !bus_wr_i && bus_addr_i[2:1] inside {2'b01, 2'b10}
        |=> $stable(high_latch_q))
        else $error("compare read disturbed the latch");

    chk_overflow_set: assert property (
        wrap && !(wr_low && bus_addr_i == ADDR_CNT_L)
        |=> overflow_flag_q && counter_value_q == WIDE_RESET)
        else $error("wrap did not set overflow");

    chk_capture_copy: assert property (
        cap_trigger |=> capture_value_q == $past(counter_value_q))
        else $error("capture did not stamp counter");

    chk_flag_same_cycle: assert property (
        $rose(capture_flag_q) |-> $past(cap_trigger)
            && capture_value_q == $past(counter_value_q))
        else $error("flag and stamp not in same cycle");

    chk_irq_request: assert property (
        cap_trigger && capture_irq_enable_i ##1 capture_irq_enable_i
        |-> capture_irq_o)
        else $error("enabled flag did not raise request");

    chk_vector_clear: assert property (
        capture_vector_ack_i && !cap_trigger |=> !capture_flag_q)
        else $error("vector did not clear flag");

    chk_write_one_clear: assert property (
        capture_flag_write_i && !cap_trigger && !capture_vector_ack_i
        |=> capture_flag_q
            == ($past(capture_flag_q) && !$past(capture_flag_wdata_i)))
        else $error("flag write did not act as write-one-clear");

    chk_cap_high_read: assert property (
        bus_rd_i && !bus_wr_i && bus_addr_i == ADDR_CAP_H
        |=> bus_rdata_o == $past(high_latch_q))
        else $error("capture high read not from latch");

    chk_cap_write_lock: assert property (
        wr_low && bus_addr_i == ADDR_CAP_L && !cap_is_top && !cap_trigger
        |=> $stable(capture_value_q))
        else $error("capture written outside top mode");

    chk_top_wrap: assert property (
        count_en_i && cap_is_top && counter_value_q == capture_value_q
        && !(wr_low && bus_addr_i == ADDR_CNT_L)
        |=> counter_value_q == WIDE_RESET && overflow_flag_q)
        else $error("capture-top mode did not wrap at capture value");

    chk_irq_masked: assert property (
        !capture_irq_enable_i |-> !capture_irq_o)
        else $error("masked capture flag raised a request");

    cov_capture_event: cover property (cap_trigger ##1 capture_irq_o);
    cov_wide_read: cover property (
        rd_low && bus_addr_i == ADDR_CAP_L
        ##1 bus_rd_i && bus_addr_i == ADDR_CAP_H);
    cov_wide_write: cover property (
        wr_high && bus_addr_i == ADDR_CNT_H
        ##1 wr_low && bus_addr_i == ADDR_CNT_L);
    cov_overflow: cover property (wrap);
    cov_top_wrap: cover property (wrap && cap_is_top);

endmodule

// file: design/timer16_pkg.sv
/*
 * Shared constants for the 16-bit timer byte access path and its
 * input capture unit. Assumes an 8-bit CPU bus with 3 address bits
 * that select one byte of one wide timer register.
 */
package timer16_pkg;

    typedef logic [2:0] byte_addr_t;

    // Byte addresses of the wide registers
    localparam byte_addr_t ADDR_CNT_L = 3'h0;
    localparam byte_addr_t ADDR_CNT_H = 3'h1;
    localparam byte_addr_t ADDR_CMPA_L = 3'h2;
    localparam byte_addr_t ADDR_CMPA_H = 3'h3;
    localparam byte_addr_t ADDR_CMPB_L = 3'h4;
    localparam byte_addr_t ADDR_CMPB_H = 3'h5;
    localparam byte_addr_t ADDR_CAP_L = 3'h6;
    localparam byte_addr_t ADDR_CAP_H = 3'h7;

    // Field positions of a wide register
    localparam int LOW_LSB = 0;
    localparam int HIGH_LSB = 8;

    // Reset values and counter maximum
    localparam logic [15:0] WIDE_RESET = 16'h0000;
    localparam logic [7:0] LATCH_RESET = 8'h00;
    localparam logic [15:0] COUNT_MAX = 16'hFFFF;

    // Waveform modes in which the capture register sets the top value
    localparam logic [15:0] CAP_TOP_MODES = 16'h5500;

    // Edge select encoding
    localparam logic EDGE_FALLING = 1'b0;
    localparam logic EDGE_RISING = 1'b1;

    // Source select encoding
    localparam logic SRC_PIN = 1'b0;
    localparam logic SRC_COMPARATOR = 1'b1;

endpackage
